// ===== verilog/chain_pkg.sv
// Shared constants and types for the pressure signal chain
package chain_pkg;

  // Clock rate and times in their own units
  localparam int CLK_KHZ        = 25000;
  localparam int DISP_TOGGLE_MS = 3000;
  localparam int SAMPLE_MS      = 10;
  localparam int DISP_CYCLES    = DISP_TOGGLE_MS * CLK_KHZ;
  localparam int SAMPLE_CYCLES  = SAMPLE_MS * CLK_KHZ;

  // Loop current levels in microamps, then numeric display limit and 100% scale
  localparam logic signed [31:0] CUR_4MA  = 32'sh0000_0FA0;
  localparam logic signed [31:0] CUR_SPAN = 32'sh0000_3E80;
  localparam logic signed [31:0] CUR_MIN  = 32'sh0000_0E10;
  localparam logic signed [31:0] CUR_MAX  = 32'sh0000_5208;
  localparam logic signed [31:0] SAT_LO   = 32'sh0000_0ED8;
  localparam logic signed [31:0] SAT_HI   = 32'sh0000_5014;
  localparam logic signed [31:0] NUM_MAX  = 32'sh0000_4E1F;
  localparam logic signed [31:0] PCT_HUND = 32'sh0000_2710;

  // Table sizes and divider length
  localparam int          CHAR_PTS   = 5;
  localparam int          LIN_PTS    = 16;
  localparam int          TEXT_WORDS = 12;
  localparam logic [5:0]  DIV_STEPS  = 6'h20;
  localparam logic [4:0]  LIN_MIN    = 5'h02;
  localparam logic [4:0]  LIN_MAX    = 5'h10;

  // Register word addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_POLL   = 8'h01;
  localparam logic [7:0] A_DAMP   = 8'h02;
  localparam logic [7:0] A_ZTRIM  = 8'h03;
  localparam logic [7:0] A_UGAIN  = 8'h04;
  localparam logic [7:0] A_RLO    = 8'h05;
  localparam logic [7:0] A_RGAIN  = 8'h06;
  localparam logic [7:0] A_LCOUNT = 8'h07;
  localparam logic [7:0] A_FIXCUR = 8'h08;
  localparam logic [7:0] A_MV     = 8'h09;
  localparam logic [7:0] A_TRIM4  = 8'h0A;
  localparam logic [7:0] A_TRIM20 = 8'h0B;
  localparam logic [7:0] A_EU0    = 8'h0C;
  localparam logic [7:0] A_EU100  = 8'h0D;
  localparam logic [7:0] A_UNIT   = 8'h0E;
  localparam logic [7:0] A_DSEL   = 8'h0F;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_PV     = 8'h11;
  localparam logic [7:0] A_CUR    = 8'h12;
  localparam logic [7:0] A_EU     = 8'h13;
  localparam logic [7:0] A_DATE   = 8'h14;
  localparam logic [7:0] A_CHAR0  = 8'h18;
  localparam logic [7:0] A_LIN0   = 8'h20;
  localparam logic [7:0] A_TEXT0  = 8'h30;

  // Control bit positions
  localparam int C_CHAR_EN = 0;
  localparam int C_LIN_EN  = 1;
  localparam int C_FIXED   = 2;
  localparam int C_SRC_MV  = 3;
  localparam int C_FAIL_HI = 4;
  localparam int C_TWO_VAR = 5;
  localparam int C_CHAR_MD = 6;

  // Values after reset
  localparam logic [15:0] UGAIN_RST  = 16'h4000;
  localparam logic [15:0] RGAIN_RST  = 16'h1000;
  localparam logic [15:0] FIXCUR_RST = 16'h0FA0;
  localparam logic [15:0] EU100_RST  = 16'h2710;

  // Alphanumeric field texts
  localparam logic [39:0] TXT_INIT = 40'h494E_4954_20;
  localparam logic [39:0] TXT_CHAR = 40'h4348_4152_20;
  localparam logic [39:0] TXT_FAIL = 40'h4641_494C_53;
  localparam logic [39:0] TXT_SATU = 40'h5341_5455_52;
  localparam logic [39:0] TXT_PCT  = 40'h5045_5243_54;
  localparam logic [39:0] TXT_UNIT = 40'h554E_4954_20;
  localparam logic [39:0] TXT_PRES = 40'h5052_4553_53;
  localparam logic [39:0] TXT_MV   = 40'h4D56_2020_20;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_FILT  = 3'h1,
    ST_CHAR  = 3'h2,
    ST_TRIM  = 3'h3,
    ST_RANGE = 3'h4,
    ST_LSRCH = 3'h5,
    ST_LDIV  = 3'h6,
    ST_OUT   = 3'h7
  } chain_st_e;

  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        master;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_s;

  // Indicator fields
  typedef struct packed {
    logic [7:0]         status;
    logic [39:0]        alpha;
    logic signed [16:0] numeric;
  } disp_s;

endpackage : chain_pkg

// ===== verilog/pressure_signal_chain.sv
// Pressure measurement chain: damping, trims, ranging, table, loop current, indicator
// Function
// - Low-pass damping; setting n moves 1/2^n of the step per interval, larger n gives longer time to 63.2%.
// - Up to five user characterization points on top of factory data.
// - Zero and upper pressure trims correct drift and offsets.
// - Range low point gives 4 mA, range high point gives 20 mA.
// - Lookup table of 2 to 16 points with interpolation.
// - Each table point holds X percent of range and Y percent of output.
// - Loop current follows process or manipulated variable by source select.
// - Fixed-current mode drives a configured constant current.
// - Commanded loop current stays within 3.6 mA and 21 mA.
// - Separate 4 mA and 20 mA current trims match an external standard.
// - Process variable 0 and 100% map to engineering units with unit.
// - Two selected variables alternate every 3 seconds on the indicator.
// - Indicator has 4.5-digit numeric, 5-character alpha and status fields.
// - Monitoring mode in normal operation, left during local adjustment.
// - Messages for initialization, characterization mode and sensor failure.
// - Saturation message when current is held at 3.8 or 20.5 mA.
// - Address zero modulates loop current 4 to 20 mA with measurement.
// - Host assigns addresses 1 to 15; device then holds 4 mA; this design still drives the failure current on a sensor fault.
// - Tag-identified devices may keep address zero and control current.
// - Requests served from primary and secondary masters.
// - Configuration access never stalls measurement or loop current.
// - Stores 16-char descriptor, 32-char message and 3-byte date.
// - On failure, loop goes to 3.6 mA or 21 mA as configured.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pressure_signal_chain
#(
  parameter int DISP_CYC   = chain_pkg::DISP_CYCLES,
  parameter int SAMPLE_CYC = chain_pkg::SAMPLE_CYCLES
)
(
  input  wire logic               core_clk,        // System clock
  input  wire logic               rst,             // Asynchronous reset
  input  wire logic               ce,              // Clock enable
  input  wire chain_pkg::reg_req_s reg_req,        // Register port request
  output logic [31:0]             reg_rdata,       // Read data, cycle after read
  input  wire logic               sample_valid,    // Pressure sample strobe
  input  wire logic signed [15:0] sample_data,     // Compensated pressure
  input  wire logic               sensor_fail_pin, // Sensor fault level
  input  wire logic               local_adj_pin,   // Local adjustment active
  output logic [15:0]             loop_current_ua, // Trimmed current command
  output chain_pkg::disp_s        disp,            // Indicator fields
  output logic                    monitoring       // Monitoring mode
);
  import chain_pkg::*;

  typedef struct packed {
    logic [7:0]                   ctrl;
    logic [3:0]                   poll_addr;
    logic [3:0]                   damp;
    logic signed [15:0]           zero_trim;
    logic [15:0]                  upper_gain;
    logic signed [15:0]           range_lo;
    logic [15:0]                  range_gain;
    logic [4:0]                   lin_count;
    logic [15:0]                  fixed_cur;
    logic signed [15:0]           mv;
    logic signed [15:0]           trim4;
    logic signed [15:0]           trim20;
    logic signed [15:0]           eu0;
    logic signed [15:0]           eu100;
    logic [7:0]                   unit;
    logic [3:0]                   disp_sel;
    logic [23:0]                  date;
    logic [CHAR_PTS-1:0][31:0]    chr;
    logic [LIN_PTS-1:0][31:0]     lin;
    logic [TEXT_WORDS-1:0][31:0]  text;
    logic [31:0]                  rdata;
    logic                         last_master;
    logic [2:0]                   sync_fail;
    logic [2:0]                   sync_adj;
    logic                         fail;
    logic                         adj;
    logic signed [15:0]           sample;
    logic [31:0]                  tick_cnt;
    logic [31:0]                  disp_cnt;
    logic                         phase;
    chain_st_e                    st;
    logic signed [23:0]           filt;
    logic signed [31:0]           work;
    logic [3:0]                   seg;
    logic [5:0]                   div_cnt;
    logic [16:0]                  rem;
    logic [31:0]                  quo;
    logic [15:0]                  den;
    logic                         neg;
    logic signed [15:0]           y0;
    logic signed [15:0]           pv;
    logic [15:0]                  cur;
    logic signed [15:0]           eu;
    logic                         saturation_message;
    logic                         init;
    logic                         mon;
    disp_s                        disp;
  } state_s;

  state_s q;
  state_s d;

  // Saturate a 32-bit signed value into 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sh0000_7FFF)
      sat16 = 16'sh7FFF;
    else if (v < -32'sh0000_8000)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // Clamp into a signed window
  function automatic logic signed [31:0] clamp(input logic signed [31:0] v, input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  logic signed [31:0] a;
  logic signed [31:0] m;
  logic signed [24:0] fdiff;
  logic signed [15:0] xi;
  logic signed [15:0] xl;
  logic signed [15:0] xh;
  logic signed [15:0] yl;
  logic signed [15:0] yh;
  logic [16:0]        r;
  logic [3:0]         last;
  logic [1:0]         vsel;
  logic signed [31:0] vnum;
  logic [39:0]        vtxt;

  // Next-state logic for the whole block
  always_comb
  begin
    d     = q;
    a     = '0;
    m     = '0;
    fdiff = '0;
    xi    = '0;
    xl    = '0;
    xh    = '0;
    yl    = '0;
    yh    = '0;
    r     = '0;
    last  = 4'(q.lin_count - 5'h01);
    vsel  = '0;
    vnum  = '0;
    vtxt  = '0;

    // Pin synchronisers; a level counts once stages two and three agree
    d.sync_fail = {q.sync_fail[1:0], sensor_fail_pin};
    d.sync_adj  = {q.sync_adj[1:0], local_adj_pin};
    if (q.sync_fail[1] == q.sync_fail[2])
      d.fail = q.sync_fail[2];
    if (q.sync_adj[1] == q.sync_adj[2])
      d.adj = q.sync_adj[2];
    d.mon = ~q.adj;

    // Sample capture and fixed processing interval
    if (sample_valid)
      d.sample = sample_data;
    d.tick_cnt = (q.tick_cnt == 32'h0000_0000) ? 32'(SAMPLE_CYC - 1) : q.tick_cnt - 32'h0000_0001;

    d.disp_cnt = (q.disp_cnt == 32'h0000_0000) ? 32'(DISP_CYC - 1) : q.disp_cnt - 32'h0000_0001;
    if (!q.ctrl[C_TWO_VAR])
      d.phase = 1'b0;
    else if (q.disp_cnt == 32'h0000_0000)
      d.phase = ~q.phase;

    // Register port; either master, no wait states
    d.rdata = '0;
    if (reg_req.wr || reg_req.rd)
      d.last_master = reg_req.master;
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        A_CTRL:   d.ctrl = reg_req.wdata[7:0];
        A_POLL:   d.poll_addr = reg_req.wdata[3:0];
        A_DAMP:   d.damp = reg_req.wdata[3:0];
        A_ZTRIM:  d.zero_trim = reg_req.wdata[15:0];
        A_UGAIN:  d.upper_gain = reg_req.wdata[15:0];
        A_RLO:    d.range_lo = reg_req.wdata[15:0];
        A_RGAIN:  d.range_gain = reg_req.wdata[15:0];
        A_LCOUNT: d.lin_count = (reg_req.wdata[4:0] < LIN_MIN) ? LIN_MIN :
                                ((reg_req.wdata[4:0] > LIN_MAX) ? LIN_MAX : reg_req.wdata[4:0]);
        A_FIXCUR: d.fixed_cur = reg_req.wdata[15:0];
        A_MV:     d.mv = reg_req.wdata[15:0];
        A_TRIM4:  d.trim4 = reg_req.wdata[15:0];
        A_TRIM20: d.trim20 = reg_req.wdata[15:0];
        A_EU0:    d.eu0 = reg_req.wdata[15:0];
        A_EU100:  d.eu100 = reg_req.wdata[15:0];
        A_UNIT:   d.unit = reg_req.wdata[7:0];
        A_DSEL:   d.disp_sel = reg_req.wdata[3:0];
        A_DATE:   d.date = reg_req.wdata[23:0];
        default:
        begin
          if (reg_req.addr >= A_CHAR0 && reg_req.addr < A_CHAR0 + 8'(CHAR_PTS))
            d.chr[3'(reg_req.addr - A_CHAR0)] = reg_req.wdata;
          // X in high half, Y in low half
          else if (reg_req.addr >= A_LIN0 && reg_req.addr < A_LIN0 + 8'(LIN_PTS))
            d.lin[reg_req.addr[3:0]] = reg_req.wdata;
          else if (reg_req.addr >= A_TEXT0 && reg_req.addr < A_TEXT0 + 8'(TEXT_WORDS))
            d.text[reg_req.addr[3:0]] = reg_req.wdata;
        end
      endcase
    end
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        A_CTRL:   d.rdata = {24'h000000, q.ctrl};
        A_POLL:   d.rdata = {28'h0000000, q.poll_addr};
        A_DAMP:   d.rdata = {28'h0000000, q.damp};
        A_ZTRIM:  d.rdata = {16'h0000, q.zero_trim};
        A_UGAIN:  d.rdata = {16'h0000, q.upper_gain};
        A_RLO:    d.rdata = {16'h0000, q.range_lo};
        A_RGAIN:  d.rdata = {16'h0000, q.range_gain};
        A_LCOUNT: d.rdata = {27'h0000000, q.lin_count};
        A_FIXCUR: d.rdata = {16'h0000, q.fixed_cur};
        A_MV:     d.rdata = {16'h0000, q.mv};
        A_TRIM4:  d.rdata = {16'h0000, q.trim4};
        A_TRIM20: d.rdata = {16'h0000, q.trim20};
        A_EU0:    d.rdata = {16'h0000, q.eu0};
        A_EU100:  d.rdata = {16'h0000, q.eu100};
        A_UNIT:   d.rdata = {24'h000000, q.unit};
        A_DSEL:   d.rdata = {28'h0000000, q.disp_sel};
        A_STATUS: d.rdata = {26'h0000000, q.last_master, q.mon, q.init, q.fail, q.saturation_message, q.phase};
        A_PV:     d.rdata = {16'h0000, q.pv};
        A_CUR:    d.rdata = {16'h0000, q.cur};
        A_EU:     d.rdata = {16'h0000, q.eu};
        A_DATE:   d.rdata = {8'h00, q.date};
        default:
        begin
          if (reg_req.addr >= A_CHAR0 && reg_req.addr < A_CHAR0 + 8'(CHAR_PTS))
            d.rdata = q.chr[3'(reg_req.addr - A_CHAR0)];
          else if (reg_req.addr >= A_LIN0 && reg_req.addr < A_LIN0 + 8'(LIN_PTS))
            d.rdata = q.lin[reg_req.addr[3:0]];
          else if (reg_req.addr >= A_TEXT0 && reg_req.addr < A_TEXT0 + 8'(TEXT_WORDS))
            d.rdata = q.text[reg_req.addr[3:0]];
        end
      endcase
    end

    // Processing sequence, one step per cycle
    unique case (q.st)
      ST_IDLE:
        if (q.tick_cnt == 32'h0000_0000)
          d.st = ST_FILT;
      ST_FILT:
      begin
        // y += (x - y) / 2^damp once per interval
        // larger setting, longer time to 63.2%
        fdiff  = 25'(signed'({q.sample, 8'h00})) - 25'(q.filt);
        d.filt = q.filt + 24'(fdiff >>> q.damp);
        d.st   = ST_CHAR;
      end
      ST_CHAR:
      begin
        a = 32'(signed'(q.filt[23:8]));
        // correction of highest point at or below the pressure
        if (q.ctrl[C_CHAR_EN])
        begin
          for (int i = 0; i < CHAR_PTS; i++)
            if (32'(signed'(q.chr[i][31:16])) <= 32'(signed'(q.filt[23:8])))
              a = 32'(signed'(q.filt[23:8])) + 32'(signed'(q.chr[i][15:0]));
        end
        d.work = a;
        d.st   = ST_TRIM;
      end
      ST_TRIM:
      begin
        m      = (q.work - 32'(q.zero_trim)) * signed'({16'h0000, q.upper_gain});
        d.work = m >>> 14;
        d.st   = ST_RANGE;
      end
      ST_RANGE:
      begin
        // low point to 0%, high point to 100% (16384)
        m      = (q.work - 32'(q.range_lo)) * signed'({16'h0000, q.range_gain});
        d.work = 32'(sat16(m >>> 12));
        d.seg  = 4'h1;
        if (q.ctrl[C_LIN_EN])
          d.st = ST_LSRCH;
        else
        begin
          d.pv = sat16(m >>> 12);
          d.st = ST_OUT;
        end
      end
      ST_LSRCH:
      begin
        // find the segment around the input
        xi = q.work[15:0];
        xl = q.lin[q.seg - 4'h1][31:16];
        xh = q.lin[q.seg][31:16];
        yl = q.lin[q.seg - 4'h1][15:0];
        yh = q.lin[q.seg][15:0];
        if (xi <= signed'(q.lin[0][31:16]))
        begin
          d.pv = q.lin[0][15:0];
          d.st = ST_OUT;
        end
        else if (xi >= signed'(q.lin[last][31:16]))
        begin
          d.pv = q.lin[last][15:0];
          d.st = ST_OUT;
        end
        // increasing X keeps the divisor positive
        else if (xi <= xh)
        begin
          m         = 32'(xi - xl) * 32'(yh - yl);
          d.neg     = m[31];
          d.quo     = m[31] ? 32'(-m) : m;
          d.rem     = '0;
          d.den     = 16'(xh - xl);
          d.y0      = yl;
          d.div_cnt = DIV_STEPS;
          d.st      = ST_LDIV;
        end
        else
          d.seg = q.seg + 4'h1;
      end
      ST_LDIV:
      begin
        // bit-serial divide for the interpolated offset above the lower point
        if (q.div_cnt == 6'h00)
        begin
          d.pv = sat16(32'(q.y0) + (q.neg ? -signed'(q.quo) : signed'(q.quo)));
          d.st = ST_OUT;
        end
        else
        begin
          r         = {q.rem[15:0], q.quo[31]};
          d.div_cnt = q.div_cnt - 6'h01;
          if (r >= {1'b0, q.den})
          begin
            d.rem = r - {1'b0, q.den};
            d.quo = {q.quo[30:0], 1'b1};
          end
          else
          begin
            d.rem = r;
            d.quo = {q.quo[30:0], 1'b0};
          end
        end
      end
      ST_OUT:
      begin
        m = 32'(q.ctrl[C_SRC_MV] ? q.mv : q.pv);
        a = CUR_4MA + ((m * CUR_SPAN) >>> 14);
        // saturation window 3.8 to 20.5 mA
        d.saturation_message = !q.ctrl[C_FIXED] && (a < SAT_LO || a > SAT_HI);
        a     = clamp(a, SAT_LO, SAT_HI);
        if (q.ctrl[C_FIXED])
          a = 32'(q.fixed_cur);
        // address zero keeps modulating; tag mode stays there
        if (q.poll_addr != 4'h0)
          a = CUR_4MA;
        if (q.fail)
          a = q.ctrl[C_FAIL_HI] ? CUR_MAX : CUR_MIN;
        // offset at 4 mA and gain toward 20 mA
        a = a + 32'(q.trim4) + (((a - CUR_4MA) * 32'(q.trim20)) >>> 14);
        d.cur = 16'(clamp(a, CUR_MIN, CUR_MAX));
        // engineering units from the 0 and 100% points
        d.eu   = sat16(32'(q.eu0) + ((32'(q.pv) * (32'(q.eu100) - 32'(q.eu0))) >>> 14));
        d.init = 1'b0;
        d.st   = ST_IDLE;
      end
    endcase

    vsel = q.phase ? q.disp_sel[3:2] : q.disp_sel[1:0];
    unique case (vsel)
      2'h0:
      begin
        vnum = (32'(q.pv) * PCT_HUND) >>> 14;
        vtxt = TXT_PCT;
      end
      2'h1:
      begin
        vnum = 32'(q.eu);
        vtxt = TXT_UNIT;
      end
      2'h2:
      begin
        vnum = 32'(signed'(q.filt[23:8]));
        vtxt = TXT_PRES;
      end
      2'h3:
      begin
        vnum = 32'(q.mv);
        vtxt = TXT_MV;
      end
    endcase
    d.disp.numeric = 17'(clamp(vnum, -NUM_MAX, NUM_MAX));
    if (q.init)
      d.disp.alpha = TXT_INIT;
    else if (q.fail)
      d.disp.alpha = TXT_FAIL;
    else if (q.ctrl[C_CHAR_MD])
      d.disp.alpha = TXT_CHAR;
    else if (q.saturation_message)
      d.disp.alpha = TXT_SATU;
    else
      d.disp.alpha = vtxt;
    d.disp.status = {2'h0, q.mon, q.phase, q.ctrl[C_CHAR_MD], q.saturation_message, q.fail, q.init};
  end

  // State register with clock enable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q            <= '0;
      q.upper_gain <= UGAIN_RST;
      q.range_gain <= RGAIN_RST;
      q.lin_count  <= LIN_MIN;
      q.fixed_cur  <= FIXCUR_RST;
      q.eu100      <= EU100_RST;
      q.st         <= ST_IDLE;
      q.init       <= 1'b1;
      q.mon        <= 1'b1;
      q.cur        <= 16'(CUR_4MA);
      q.disp.alpha <= TXT_INIT;
    end
    else if (ce)
      q <= d;
  end

  // Outputs straight from the state register
  assign reg_rdata       = q.rdata;
  assign loop_current_ua = q.cur;
  assign disp            = q.disp;
  assign monitoring      = q.mon;

endmodule : pressure_signal_chain

// ===== dv/chain_props.sv
// Port checks for the pressure signal chain
`timescale 1ns/1ps
module chain_props
  import chain_pkg::*;
(
  input wire logic               core_clk,        // Clock
  input wire logic               rst,             // Reset
  input wire logic               ce,              // Clock enable
  input wire chain_pkg::reg_req_s reg_req,        // Register request
  input wire logic [31:0]        reg_rdata,       // Read data
  input wire logic               sample_valid,    // Sample strobe
  input wire logic signed [15:0] sample_data,     // Sample
  input wire logic               sensor_fail_pin, // Sensor fault
  input wire logic               local_adj_pin,   // Local adjustment
  input wire logic [15:0]        loop_current_ua, // Current command
  input wire chain_pkg::disp_s   disp,            // Indicator
  input wire logic               monitoring       // Monitoring mode
);
  logic [7:0] fail_cnt_q, ok_cnt_q, up_cnt_q;
  // Saturating run lengths of the fault pin and time since reset
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      fail_cnt_q <= 8'h00;
      ok_cnt_q   <= 8'h00;
      up_cnt_q   <= 8'h00;
    end
    else
    begin
      fail_cnt_q <= !sensor_fail_pin ? 8'h00 : fail_cnt_q + {7'h00, fail_cnt_q != 8'hFF};
      ok_cnt_q   <= sensor_fail_pin ? 8'h00 : ok_cnt_q + {7'h00, ok_cnt_q != 8'hFF};
      up_cnt_q   <= up_cnt_q + {7'h00, up_cnt_q != 8'hFF};
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence adj_held; local_adj_pin [*7]; endsequence
  sequence adj_free; !local_adj_pin [*7]; endsequence
  sequence init_hold; (disp.alpha == TXT_INIT) [*3]; endsequence
  cur_range_a: assert property (loop_current_ua >= 16'h0E10 && loop_current_ua <= 16'h5208)
    else $error("loop current outside limits");
  rdata_idle_a: assert property (ce && !reg_req.rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  unmapped_rd_a: assert property (ce && reg_req.rd && reg_req.addr == 8'hFF |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  fail_msg_a: assert property (fail_cnt_q >= 8'h10 |-> disp.status[1] && disp.alpha == TXT_FAIL)
    else $error("sensor fault message missing");
  fail_clear_a: assert property (ok_cnt_q >= 8'h10 |-> !disp.status[1])
    else $error("sensor fault flag stuck");
  init_shown_a: assert property ($fell(rst) |-> init_hold)
    else $error("init text missing after reset");
  init_gone_a: assert property (up_cnt_q == 8'hFF |-> disp.alpha != TXT_INIT)
    else $error("init text never cleared");
  mon_off_a: assert property (adj_held |-> !monitoring)
    else $error("monitoring during local adjustment");
  mon_on_a: assert property (adj_free |-> monitoring)
    else $error("monitoring not restored");
endmodule : chain_props

// ===== dv/hart_host_model.sv
// Configuring host on the register port
`timescale 1ns/1ps
module hart_host_model
  import chain_pkg::*;
(
  input  wire logic core_clk, // Clock
  output reg_req_s  reg_req   // Register request
);
  logic mst = 1'b0;
  initial reg_req = '0;
  // One-cycle strobe, then idle with scrambled address and data
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: w, rd: !w, master: mst, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, master: mst, addr: ~a, wdata: ~d};
  endtask : access
endmodule : hart_host_model

// ===== dv/pressure_signal_chain_tb_top.sv
// Self-checking bench for the pressure signal chain
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module pressure_signal_chain_tb_top;
  import chain_pkg::*;
  logic core_clk = 0, rst = 1, ce = 1, sample_valid = 0, sensor_fail_pin = 0, local_adj_pin = 0, rd_q = 0, monitoring;
  logic signed [15:0] sample_data = 16'sh0000;
  logic [31:0] reg_rdata, seed = 32'hB572AE7E;
  logic [15:0] loop_current_ua;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  disp_s disp;
  reg_req_s reg_req;
  int n_mismatch = 0, n_checks = 0;
  always #20 core_clk = ~core_clk;
  hart_host_model host_u (.core_clk(core_clk), .reg_req(reg_req));
  pressure_signal_chain #(.DISP_CYC(20), .SAMPLE_CYC(64)) dut_u (.core_clk(core_clk), .rst(rst), .ce(ce),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_data(sample_data),
    .sensor_fail_pin(sensor_fail_pin), .local_adj_pin(local_adj_pin), .loop_current_ua(loop_current_ua),
    .disp(disp), .monitoring(monitoring));
  // Compare each read answer with the oldest note
  always @(posedge core_clk)
  begin
    rd_q <= reg_req.rd;
    if (rd_q)
    begin
      note = exp_q.pop_front();
      `CHK(reg_rdata & note[63:32], note[31:0])
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    host_u.access(1'b1, a, d);
  endtask : w
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back({m, e});
    host_u.access(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic tally_and_finish();
    repeat (3) @(posedge core_clk);
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Wait for the loop current, then read it back
  task automatic wait_cur(input logic [15:0] e, input string s);
    int i;
    for (i = 0; i < 400 && loop_current_ua !== e; i++)
      @(negedge core_clk);
    if (i == 400)
    begin
      n_mismatch++;
      $display("[FAIL] %0t current %h in %s", $time, loop_current_ua, s);
      tally_and_finish();
    end
    rd(A_CUR, {16'h0000, e});
    $display("test %s done", s);
  endtask : wait_cur
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    sample_valid <= 1'b1;
    rd(A_UGAIN, 32'h0000_4000);
    rd(A_RGAIN, 32'h0000_1000);
    rd(A_LCOUNT, 32'h0000_0002);
    rd(A_FIXCUR, 32'h0000_0FA0);
    rd(A_EU100, 32'h0000_2710);
    sample_data <= 16'sh7000;
    wait_cur(16'h5014, "sat_high");
    rd(A_STATUS, 32'h0000_0002, 32'h0000_0002);
    w(A_POLL, 32'h0000_0005);
    wait_cur(16'h0FA0, "multidrop");
    w(A_POLL, 32'h0000_0000);
    sample_data <= -16'sh7000;
    wait_cur(16'h0ED8, "sat_low");
    w(A_FIXCUR, 32'h0000_2EE0);
    w(A_CTRL, 32'h0000_0004);
    wait_cur(16'h2EE0, "fixed");
    w(A_FIXCUR, 32'h0000_61A8);
    wait_cur(16'h5208, "clamp");
    sensor_fail_pin <= 1'b1;
    wait_cur(16'h0E10, "fail_low");
    w(A_CTRL, 32'h0000_0014);
    wait_cur(16'h5208, "fail_high");
    sensor_fail_pin <= 1'b0;
    w(A_LCOUNT, 32'h0000_0001);
    rd(A_LCOUNT, 32'h0000_0002);
    w(A_LCOUNT, 32'h0000_0014);
    rd(A_LCOUNT, 32'h0000_0010);
    w(8'hFF, 32'h1234_5678);
    rd(8'hFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      host_u.mst = seed[0];
      w(A_DATE, {8'h00, seed[23:0]});
      rd(A_DATE, {8'h00, seed[23:0]}, 32'h00FF_FFFF);
      w(A_TEXT0 + 8'(i * 3), seed);
      rd(A_TEXT0 + 8'(i * 3), seed);
      rd(A_STATUS, {26'h0, seed[0], 5'h0}, 32'h0000_0020);
    end
    $display("test registers done");
    local_adj_pin <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(A_STATUS, 32'h0000_0000, 32'h0000_0010);
    local_adj_pin <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(A_STATUS, 32'h0000_0010, 32'h0000_0010);
    $display("test local_adjust done");
    w(A_LCOUNT, 32'h0000_0002);
    w(A_LIN0 + 8'h01, 32'h4000_2000);
    w(A_CTRL, 32'h0000_0002);
    sample_data <= 16'sh2000;
    wait_cur(16'h1F40, "table");
    rd(A_PV, 32'h0000_1000);
    rd(A_EU, 32'h0000_09C4);
    `CHK(disp, {8'h20, TXT_PCT, 17'h009C4})
    // Clock enable low freezes every stage
    ce <= 1'b0;
    sample_data <= 16'sh0000;
    repeat (80) @(posedge core_clk);
    `CHK(loop_current_ua, 16'h1F40)
    ce <= 1'b1;
    w(A_MV, 32'h0000_2000);
    w(A_CTRL, 32'h0000_0008);
    wait_cur(16'h2EE0, "source_mv");
    tally_and_finish();
  end
endmodule : pressure_signal_chain_tb_top
bind pressure_signal_chain chain_props chk_u (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_data(sample_data), .sensor_fail_pin(sensor_fail_pin),
  .local_adj_pin(local_adj_pin), .loop_current_ua(loop_current_ua), .disp(disp), .monitoring(monitoring));
